/* rtl/bewg_guard.sv */
/*
  Byte FIFO and the encrypted-write command guard that parses packets,
  checks protection state and times the setting and lifecycle phases.
  Assumes link bytes, protection state and controller handshakes all
  come from logic on I_MCLK.
*/
`timescale 1ns/1ps

module bewg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // Fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("FIFO depth must be a power of two, at least 2.");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
  assign o_out_valid = (count != '0);
  assign o_out_data  = mem[rptr];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wptr] <= i_in_data;
    end
  end

  // Ready is registered so the top can hand it straight to its port.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wptr       <= '0;
      rptr       <= '0;
      count      <= '0;
      o_in_ready <= 1'b0;
    end else begin
      wptr       <= wptr + AW'(push);
      rptr       <= rptr + AW'(pop);
      count      <= next_count;
      o_in_ready <= (next_count != (AW+1)'(DEPTH));
    end
  end

endmodule // bewg_fifo

module bewg_guard
  #(
  parameter int N_AREA            = 8,
  parameter int FIFO_DEPTH        = 4,
  parameter int INIT_MAIN_CYCLES  = bewg_pkg::INIT_MAIN_CYC,
  parameter int INIT_FAST_CYCLES  = bewg_pkg::INIT_FAST_CYC,
  parameter int SETTING2_CYCLES   = bewg_pkg::SETTING2_CYC,
  parameter int LC_RESPONSE_CYCLES = bewg_pkg::LC_RESPONSE_CYC
) (
  // Clock and reset
  input  wire logic                I_MCLK,
  input  wire logic                I_SYS_RST,
  // Link byte stream
  input  wire logic                I_RX_VALID,
  input  wire logic [7:0]          I_RX_DATA,
  output logic                     O_RX_READY,
  // Protection state
  input  wire logic                I_BOOT_FLAG,
  input  wire logic                I_SECURE_PROTECT,
  input  wire logic [N_AREA-1:0]   I_PBP_MASK,
  input  wire logic [N_AREA-1:0]   I_LOCK_MASK,
  input  wire logic [N_AREA-1:0]   I_PROT_MASK,
  input  wire logic [N_AREA-1:0]   I_PBP_CFG_MASK,
  // Initial setting
  input  wire logic                I_OSC_INTERNAL,
  input  wire logic                I_SETUP_DONE,
  input  wire logic                I_SETUP2_DONE,
  // Lifecycle controller
  output logic                     O_LC_REQ,
  output logic [7:0]               O_LC_PATTERN,
  input  wire logic                I_LC_DONE,
  input  wire logic                I_LC_OK,
  // Answers and state
  output logic                     O_RSP_VALID,
  output bewg_pkg::bewg_rsp_type   O_RSP,
  output logic                     O_ERASE_REQ,
  output logic                     O_CMD_READY,
  output logic                     O_DATA_PHASE,
  output logic                     O_INIT_LATE
);
  import bewg_pkg::*;

  localparam int AW = $clog2(N_AREA);

  initial begin
    if (N_AREA < 2 || N_AREA > 128 || INIT_MAIN_CYCLES < 1 || INIT_FAST_CYCLES < 1
        || SETTING2_CYCLES < 1 || LC_RESPONSE_CYCLES < 1) begin
      $error("Unsupported area count or zero timing count.");
    end
  end

  typedef enum logic [3:0] {
    ST_INIT1   = 4'h0,
    ST_INIT2   = 4'h1,
    ST_START   = 4'h2,
    ST_LENH    = 4'h3,
    ST_LENL    = 4'h4,
    ST_BODY    = 4'h5,
    ST_SUM     = 4'h6,
    ST_END     = 4'h7,
    ST_EXEC    = 4'h8,
    ST_LC_WAIT = 4'h9
  } bewg_state_type;

  // ---------------------------------------------------------------
  // Input buffer
  // ---------------------------------------------------------------
  logic       byte_valid;
  logic [7:0] byte_data;
  logic       rx_state;
  logic       take;

  bewg_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk       (I_MCLK),
    .i_rst       (I_SYS_RST),
    .i_in_valid  (I_RX_VALID),
    .i_in_data   (I_RX_DATA),
    .o_in_ready  (O_RX_READY),
    .o_out_valid (byte_valid),
    .o_out_data  (byte_data),
    .i_out_ready (rx_state)
  );

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  bewg_state_type state;
  bewg_state_type next_state;
  logic [31:0]    timer;
  logic [15:0]    len;
  logic [15:0]    cnt;
  logic [7:0]     sum;
  logic [7:0]     start;
  logic [7:0]     b0;
  logic [7:0]     b1;
  logic [7:0]     b2;
  logic           etx_ok;
  logic           data_phase;
  logic           pbp_seen;

  assign rx_state = (state >= ST_START) && (state <= ST_END);
  assign take     = rx_state && byte_valid;

  // ---------------------------------------------------------------
  // Decoding of a finished packet
  // ---------------------------------------------------------------
  wire [AW-1:0] area       = b1[AW-1:0];
  wire          area_ok    = (b1 < 8'(N_AREA));
  wire          is_data    = (start == START_DATA_BYTE);
  wire          is_cancel  = is_data && (len == CANCEL_LEN) && (b0 == CANCEL_CODE);
  wire          any_pbp    = |I_PBP_MASK;
  wire          no_boot    = !I_BOOT_FLAG && !I_SECURE_PROTECT;
  wire [31:0]   init_limit = I_OSC_INTERNAL ? 32'(INIT_FAST_CYCLES) : 32'(INIT_MAIN_CYCLES);
  wire          init_late  = (timer >= init_limit - 32'h1);
  wire          set2_late  = (timer >= 32'(SETTING2_CYCLES) - 32'h1);
  wire          lc_late    = (timer >= 32'(LC_RESPONSE_CYCLES) - 32'h1);

  bewg_status_type ex_status;
  logic            ex_reply;
  logic            ex_lc;
  logic            ex_enter;
  logic            ex_leave;
  logic            ex_erase;

  always_comb begin
    ex_status = STS_OK;
    ex_reply  = 1'b1;
    ex_lc     = 1'b0;
    ex_enter  = 1'b0;
    ex_leave  = 1'b0;
    ex_erase  = 1'b0;
    if (!etx_ok || len == 16'h0000) begin
      ex_status = STS_PACKET;
    end else if (sum != 8'h00) begin
      ex_status = STS_CHECKSUM;
    end else if (data_phase && is_cancel) begin
      ex_reply = 1'b0;
      ex_leave = 1'b1;
    end else if (data_phase != is_data) begin
      ex_status = STS_PACKET;
    end else if (data_phase) begin
      if (len != LEN_ENC_DATA || b0 != CMD_ENC_WRITE) begin
        ex_status = STS_PACKET;
      end else if (!area_ok) begin
        ex_status = STS_PARAM;
      end else if (I_LOCK_MASK[area]) begin
        ex_status = STS_PROTECT;
      end else if (I_PROT_MASK[area] && pbp_seen) begin
        ex_status = STS_PROTECT;
      end
      ex_leave = (ex_status != STS_OK) || b2[0];
      ex_erase = (ex_status != STS_OK);
    end else begin
      unique case (b0)
        CMD_ENC_WRITE: begin
          if (len != LEN_ENC_WRITE) begin
            ex_status = STS_PACKET;
          end else if (any_pbp) begin
            ex_status = STS_PROTECT;
          end else if (no_boot) begin
            ex_status = STS_PROTECT;
          end else begin
            ex_enter = 1'b1;
          end
        end
        CMD_USER_KEY, CMD_CERT_UPDATE: begin
          if (len != LEN_AREA_CMD) begin
            ex_status = STS_PACKET;
          end else if (!area_ok) begin
            ex_status = STS_PARAM;
          end else if (I_PBP_MASK[area]) begin
            ex_status = STS_PROTECT;
          end
        end
        CMD_LC_TRANSIT: begin
          if (len != LEN_AREA_CMD) begin
            ex_status = STS_PACKET;
          end else begin
            ex_reply = 1'b0;
            ex_lc    = 1'b1;
          end
        end
        default: begin
          ex_status = STS_CMD_ACCEPT;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      ST_INIT1: begin
        if (I_SETUP_DONE || init_late) begin
          next_state = ST_INIT2;
        end
      end
      ST_INIT2: begin
        if (I_SETUP2_DONE || set2_late) begin
          next_state = ST_START;
        end
      end
      ST_START: begin
        if (take && (byte_data == START_CMD_BYTE || byte_data == START_DATA_BYTE)) begin
          next_state = ST_LENH;
        end
      end
      ST_LENH: begin
        if (take) begin
          next_state = ST_LENL;
        end
      end
      ST_LENL: begin
        if (take) begin
          next_state = ({len[7:0], byte_data} == 16'h0000) ? ST_SUM : ST_BODY;
        end
      end
      ST_BODY: begin
        if (take && cnt == len - 16'h1) begin
          next_state = ST_SUM;
        end
      end
      ST_SUM: begin
        if (take) begin
          next_state = ST_END;
        end
      end
      ST_END: begin
        if (take) begin
          next_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        next_state = ex_lc ? ST_LC_WAIT : ST_START;
      end
      ST_LC_WAIT: begin
        if (I_LC_DONE || lc_late) begin
          next_state = ST_START;
        end
      end
      default: begin
        next_state = ST_START;
      end
    endcase
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      state <= ST_INIT1;
      timer <= 32'h0;
    end else begin
      state <= next_state;
      timer <= (next_state != state) ? 32'h0 : timer + 32'h1;
    end
  end

  // Packet capture. Only the first three payload bytes matter here.
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      len    <= 16'h0;
      cnt    <= 16'h0;
      sum    <= 8'h0;
      start  <= 8'h0;
      b0     <= 8'h0;
      b1     <= 8'h0;
      b2     <= 8'h0;
      etx_ok <= 1'b0;
    end else if (take) begin
      unique case (state)
        ST_START: begin
          start <= byte_data;
          sum   <= 8'h0;
          cnt   <= 16'h0;
        end
        ST_LENH: begin
          len <= {8'h00, byte_data};
          sum <= sum + byte_data;
        end
        ST_LENL: begin
          len <= {len[7:0], byte_data};
          sum <= sum + byte_data;
        end
        ST_BODY: begin
          if (cnt == 16'h0) b0 <= byte_data;
          if (cnt == 16'h1) b1 <= byte_data;
          if (cnt == 16'h2) b2 <= byte_data;
          cnt <= cnt + 16'h1;
          sum <= sum + byte_data;
        end
        ST_SUM: begin
          sum <= sum + byte_data;
        end
        default: begin
          etx_ok <= (byte_data == END_BYTE);
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Command phase and answers
  // ---------------------------------------------------------------
  wire exec    = (state == ST_EXEC);
  wire lc_end  = (state == ST_LC_WAIT) && (I_LC_DONE || lc_late);
  wire enter   = exec && ex_enter;
  wire leave   = exec && (ex_leave || (ex_status != STS_OK));
  wire pbp_hit = exec && data_phase && is_data && area_ok && (ex_status == STS_OK)
                 && I_PBP_CFG_MASK[area];

  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      data_phase <= 1'b0;
      pbp_seen   <= 1'b0;
    end else begin
      data_phase <= enter || (data_phase && !leave);
      pbp_seen   <= !enter && !leave && (pbp_seen || pbp_hit);
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      O_RSP_VALID  <= 1'b0;
      O_RSP        <= '0;
      O_ERASE_REQ  <= 1'b0;
      O_LC_REQ     <= 1'b0;
      O_LC_PATTERN <= 8'h0;
      O_CMD_READY  <= 1'b0;
      O_DATA_PHASE <= 1'b0;
      O_INIT_LATE  <= 1'b0;
    end else begin
      O_RSP_VALID  <= (exec && ex_reply) || lc_end;
      if (exec) begin
        O_RSP <= '{status: ex_status, code: b0};
      end else if (lc_end) begin
        O_RSP <= '{status: (I_LC_DONE && I_LC_OK) ? STS_OK : STS_HARDWARE,
                   code: CMD_LC_TRANSIT};
      end
      O_ERASE_REQ  <= exec && ex_erase;
      O_LC_REQ     <= exec && ex_lc;
      if (exec && ex_lc) begin
        O_LC_PATTERN <= b1;
      end
      O_CMD_READY  <= (next_state == ST_START) && !enter && !(data_phase && !leave);
      O_DATA_PHASE <= enter || (data_phase && !leave);
      O_INIT_LATE  <= O_INIT_LATE
                      || (state == ST_INIT1 && !I_SETUP_DONE && init_late)
                      || (state == ST_INIT2 && !I_SETUP2_DONE && set2_late);
    end
  end

endmodule // bewg_guard

/* rtl/bewg_pkg.sv */
/*
  Shared constants and types of the encrypted-write command guard.
  Assumes a single 40 MHz clock domain and a byte-wide packet link.
*/
// What this block does
// - Refuse encrypted write once permanent protection exists.
// - Refuse encrypted write when boot and secure bits zero.
// - Reject rewrite of areas whose lock bit set.
// - Protection error when key/certificate target permanently protected.
// - Write failure leaves user and data area erased; checksum, framing and command-packet errors end the data phase without erase.
// - Error packet cancels multi-packet command, back to idle.
// - Initial setting done within 137 ms, main oscillator.
// - Initial setting done within 2773 ms, internal oscillator.
// - Second setting stage done within 82 ms.
// - Lifecycle transit command answered within 3 seconds.
// - Packet, length or parameter error returns to idle.
package bewg_pkg;

  // ---------------------------------------------------------------
  // Packet framing
  // ---------------------------------------------------------------
  localparam logic [7:0]  START_CMD_BYTE  = 8'h01;
  localparam logic [7:0]  START_DATA_BYTE = 8'h81;
  localparam logic [7:0]  END_BYTE        = 8'h03;
  localparam logic [7:0]  CANCEL_CODE     = 8'hff;
  localparam logic [15:0] CANCEL_LEN      = 16'h0001;

  // ---------------------------------------------------------------
  // Command codes and payload lengths
  // ---------------------------------------------------------------
  localparam logic [7:0]  CMD_ENC_WRITE   = 8'h3a;
  localparam logic [7:0]  CMD_USER_KEY    = 8'h29;
  localparam logic [7:0]  CMD_CERT_UPDATE = 8'h2c;
  localparam logic [7:0]  CMD_LC_TRANSIT  = 8'h71;
  localparam logic [15:0] LEN_ENC_WRITE   = 16'h0001;
  localparam logic [15:0] LEN_AREA_CMD    = 16'h0002;
  localparam logic [15:0] LEN_ENC_DATA    = 16'h0003;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam longint MCLK_HZ         = 40_000_000;
  localparam longint INIT_MAIN_MS    = 137;
  localparam longint INIT_FAST_MS    = 2773;
  localparam longint SETTING2_MS     = 82;
  localparam longint LC_RESPONSE_S   = 3;
  localparam int     INIT_MAIN_CYC   = int'(INIT_MAIN_MS * MCLK_HZ / 1000);
  localparam int     INIT_FAST_CYC   = int'(INIT_FAST_MS * MCLK_HZ / 1000);
  localparam int     SETTING2_CYC    = int'(SETTING2_MS * MCLK_HZ / 1000);
  localparam int     LC_RESPONSE_CYC = int'(LC_RESPONSE_S * MCLK_HZ);

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    STS_OK         = 4'h0,
    STS_PACKET     = 4'h1,
    STS_CHECKSUM   = 4'h2,
    STS_CMD_ACCEPT = 4'h3,
    STS_PROTECT    = 4'h4,
    STS_PARAM      = 4'h5,
    STS_HARDWARE   = 4'h6
  } bewg_status_type;

  typedef struct packed {
    bewg_status_type status;
    logic [7:0]      code;
  } bewg_rsp_type;

endpackage

/* tb/bewg_guard_assertions.sv */
/*
  Port checker for the encrypted-write command guard.
  Assumes it is bound to bewg_guard and sees only its ports.
*/
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Checker
// ---------------------------------------------------------------
module bewg_guard_assertions
  import bewg_pkg::*;
#(
  parameter int N_AREA             = 8,
  parameter int INIT_MAIN_CYCLES   = 20,
  parameter int SETTING2_CYCLES    = 10,
  parameter int LC_RESPONSE_CYCLES = 30
) (
  // Clock and reset
  input wire logic                   I_MCLK,
  input wire logic                   I_SYS_RST,
  // Protection state, setting and lifecycle inputs
  input wire logic                   I_BOOT_FLAG,
  input wire logic                   I_SECURE_PROTECT,
  input wire logic [N_AREA-1:0]      I_PBP_MASK,
  input wire logic                   I_LC_DONE,
  input wire logic                   I_LC_OK,
  input wire logic                   I_SETUP_DONE,
  // Outputs
  input wire logic                   O_LC_REQ,
  input wire logic                   O_RSP_VALID,
  input wire bewg_pkg::bewg_rsp_type O_RSP,
  input wire logic                   O_ERASE_REQ,
  input wire logic                   O_CMD_READY,
  input wire logic                   O_DATA_PHASE,
  input wire logic                   O_INIT_LATE
);
  localparam int LC_MAX = LC_RESPONSE_CYCLES + 2;
  // Slack of a few cycles so a deadline counted from either edge passes.
  localparam int LATE_MIN  = INIT_MAIN_CYCLES - 3;
  localparam int S2_MIN    = SETTING2_CYCLES - 3;
  localparam int SINCE_CAP = INIT_MAIN_CYCLES + SETTING2_CYCLES;
  logic lc_wait;
  logic s1_seen;
  int   since;
  // The second stage's deadline runs from the end of the first, so the count restarts there.
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      lc_wait <= 1'b0;
      s1_seen <= 1'b0;
      since   <= 0;
    end else begin
      if (O_LC_REQ) lc_wait <= 1'b1;
      else if (O_RSP_VALID) lc_wait <= 1'b0;
      if (I_SETUP_DONE && !s1_seen) begin
        s1_seen <= 1'b1;
        since   <= 0;
      end else if (since < SINCE_CAP) begin
        since <= since + 1;
      end
    end
  end
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_SYS_RST);
  a_pbp_blocks_entry: assert property ($rose(O_DATA_PHASE) |-> $past(I_PBP_MASK) == '0)
    else $error("data phase entered with permanent protection");
  a_boot_bits_entry: assert property ($rose(O_DATA_PHASE) |->
    $past(I_BOOT_FLAG | I_SECURE_PROTECT)) else $error("data phase entered, bits zero");
  a_entry_answer_ok: assert property ($rose(O_DATA_PHASE) |-> O_RSP_VALID &&
    O_RSP.status == STS_OK && O_RSP.code == CMD_ENC_WRITE) else $error("entry without OK");
  a_erase_on_fail: assert property (O_ERASE_REQ |-> O_RSP_VALID &&
    O_RSP.status != STS_OK) else $error("erase without failing answer");
  a_erase_ends_phase: assert property (O_ERASE_REQ |-> ##[0:1] !O_DATA_PHASE)
    else $error("data phase kept after erase");
  a_phase_excl_ready: assert property (O_DATA_PHASE |-> !O_CMD_READY)
    else $error("command ready during data phase");
  a_lc_answer_now: assert property (lc_wait && I_LC_DONE |=> O_RSP_VALID &&
    O_RSP.status == ($past(I_LC_OK) ? STS_OK : STS_HARDWARE)) else $error("bad lc answer");
  a_lc_answer_bound: assert property (O_LC_REQ |-> ##[1:LC_MAX] O_RSP_VALID)
    else $error("lifecycle answer too late");
  a_late_not_early: assert property ($rose(O_INIT_LATE) |->
    since >= (s1_seen ? S2_MIN : LATE_MIN))
    else $error("setting flagged late too early");
  a_error_to_idle: assert property (O_RSP_VALID && O_RSP.status != STS_OK |->
    ##[0:1] O_CMD_READY) else $error("no return to idle after error");
  c_enter: cover property ($rose(O_DATA_PHASE));
  c_erase: cover property (O_ERASE_REQ);
  c_lc_done: cover property (lc_wait && I_LC_DONE);
endmodule // bewg_guard_assertions

bind bewg_guard bewg_guard_assertions #(.N_AREA(N_AREA), .INIT_MAIN_CYCLES(INIT_MAIN_CYCLES),
  .SETTING2_CYCLES(SETTING2_CYCLES), .LC_RESPONSE_CYCLES(LC_RESPONSE_CYCLES)) u_chk (.I_MCLK,
  .I_SYS_RST, .I_BOOT_FLAG, .I_SECURE_PROTECT, .I_PBP_MASK, .I_LC_DONE, .I_LC_OK,
  .I_SETUP_DONE, .O_LC_REQ, .O_RSP_VALID, .O_RSP,
  .O_ERASE_REQ, .O_CMD_READY, .O_DATA_PHASE, .O_INIT_LATE);

/* tb/bewg_host.sv */
/*
  Model of the host programming tool on the byte link.
  Assumes the guard samples valid and ready on the rising clock edge.
*/
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Host link model
// ---------------------------------------------------------------
module bewg_host (
  // Clock
  input  wire logic       i_clk,
  // Byte link
  output logic            o_valid,
  output logic [7:0]      o_data,
  input  wire logic       i_ready
);
  logic [7:0] q[$];
  logic       taken;
  initial begin
    o_valid = 1'b0;
    o_data  = 8'h00;
    taken   = 1'b0;
  end
  // A byte leaves the queue only after an edge that saw ready high.
  always @(posedge i_clk) taken <= o_valid & i_ready;
  always @(negedge i_clk) begin
    if (taken) void'(q.pop_front());
    if (q.size() > 0) begin
      o_valid = 1'b1;
      o_data  = q[0];
    end else begin
      // Idle data toggles so a stale byte is never mistaken for a live one.
      o_valid = 1'b0;
      o_data  = ~o_data;
    end
  end
  // The model never touches external flash, so no driver load is owed.
  task automatic send(input logic [7:0] b);
    q.push_back(b);
  endtask
  task automatic cancel();
    logic [7:0] c[6] = '{8'h81, 8'h00, 8'h01, 8'hff, 8'h00, 8'h03};
    foreach (c[i]) q.push_back(c[i]);
  endtask
endmodule // bewg_host

/* tb/bewg_guard_test.sv */
/*
  Self-checking bench of the encrypted-write command guard.
  Assumes small timing parameters so every deadline is reached quickly.
*/
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Bench
// ---------------------------------------------------------------
module bewg_guard_test;
  import bewg_pkg::*;
  localparam int T_MAIN = 20;
  localparam int T_FAST = 40;
  localparam int T_S2 = 10;
  localparam int T_LC = 30;
  logic mclk, rst, rx_valid, rx_ready, boot, secp, osc, s1, s2;
  logic lc_req, lc_done, lc_ok, rsp_valid, erase, cmd_rdy, data_ph, late;
  logic [7:0] rx_data, lc_pat, pbp, lck, prot, cfg;
  bewg_rsp_type rsp;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  bewg_guard #(.INIT_MAIN_CYCLES(T_MAIN), .INIT_FAST_CYCLES(T_FAST), .SETTING2_CYCLES(T_S2),
    .LC_RESPONSE_CYCLES(T_LC)) dut (.I_MCLK(mclk), .I_SYS_RST(rst), .I_RX_VALID(rx_valid),
    .I_RX_DATA(rx_data), .O_RX_READY(rx_ready), .I_BOOT_FLAG(boot), .I_SECURE_PROTECT(secp),
    .I_PBP_MASK(pbp), .I_LOCK_MASK(lck), .I_PROT_MASK(prot), .I_PBP_CFG_MASK(cfg),
    .I_OSC_INTERNAL(osc), .I_SETUP_DONE(s1), .I_SETUP2_DONE(s2), .O_LC_REQ(lc_req),
    .O_LC_PATTERN(lc_pat), .I_LC_DONE(lc_done), .I_LC_OK(lc_ok), .O_RSP_VALID(rsp_valid),
    .O_RSP(rsp), .O_ERASE_REQ(erase), .O_CMD_READY(cmd_rdy), .O_DATA_PHASE(data_ph),
    .O_INIT_LATE(late));
  bewg_host host (.i_clk(mclk), .o_valid(rx_valid), .o_data(rx_data), .i_ready(rx_ready));
  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (err_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic do_rst();
    rst = 1'b1;
    ticks(2);
    rst = 1'b0;
  endtask
  task automatic pkt(input logic [7:0] st, c, a, l, input int n);
    logic [7:0] b[3];
    logic [7:0] s;
    b = '{c, a, l};
    s = 8'h00 - 8'(n);
    for (int i = 0; i < n; i++) s = s - b[i];
    host.send(st);
    host.send(8'h00);
    host.send(8'(n));
    for (int i = 0; i < n; i++) host.send(b[i]);
    host.send(s);
    host.send(8'h03);
  endtask
  // A zero code means the answer's code field is not judged.
  task automatic rsp_is(input bewg_status_type st, input logic [7:0] c, input logic er,
                        input int lim);
    int k;
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (rsp_valid !== 1'b1 && k < lim);
    chk("rsp_valid", 1, rsp_valid);
    chk("rsp_status", st, rsp.status);
    if (c !== 8'h00) chk("rsp_code", c, rsp.code);
    chk("erase_req", er, erase);
  endtask
  task automatic enter();
    pkt(8'h01, CMD_ENC_WRITE, 8'h00, 8'h00, 1);
    rsp_is(STS_OK, CMD_ENC_WRITE, 1'b0, 40);
  endtask
  task automatic t_init();
    ticks(T_MAIN + T_S2 + 6);
    chk("cmd_ready", 1, cmd_rdy);
    osc = 1'b1;
    do_rst();
    ticks(T_MAIN + T_S2 + 6);
    chk("cmd_ready", 0, cmd_rdy);
    ticks(T_FAST - T_MAIN + 2);
    chk("cmd_ready", 1, cmd_rdy);
    chk("init_late", 1, late);
    s1 = 1'b1;
    do_rst();
    ticks(T_S2 + 6);
    chk("cmd_ready", 1, cmd_rdy);
    chk("init_late", 1, late);
    s2 = 1'b1;
    do_rst();
    ticks(6);
    chk("init_late", 0, late);
    {osc, s1, s2} = 3'b000;
    do_rst();
    ticks(4);
    s1 = 1'b1;
    ticks(1);
    s1 = 1'b0;
    ticks(T_S2 - 4);
    chk("cmd_ready", 0, cmd_rdy);
    s2 = 1'b1;
    ticks(1);
    s2 = 1'b0;
    ticks(2);
    chk("cmd_ready", 1, cmd_rdy);
    chk("init_late", 0, late);
  endtask
  task automatic t_enc();
    enter();
    chk("data_phase", 1, data_ph);
    pkt(8'h81, CMD_ENC_WRITE, 8'h01, 8'h00, 3);
    rsp_is(STS_OK, CMD_ENC_WRITE, 1'b0, 40);
    host.cancel();
    ticks(12);
    chk("cmd_ready", 1, cmd_rdy);
    boot = 1'b0;
    enter();
    pkt(8'h81, CMD_ENC_WRITE, 8'h02, 8'h01, 3);
    rsp_is(STS_OK, CMD_ENC_WRITE, 1'b0, 40);
    ticks(2);
    chk("data_phase", 0, data_ph);
    secp = 1'b0;
    pkt(8'h01, CMD_ENC_WRITE, 8'h00, 8'h00, 1);
    rsp_is(STS_PROTECT, 8'h00, 1'b0, 40);
    boot = 1'b1;
    pbp = 8'h80;
    pkt(8'h01, CMD_ENC_WRITE, 8'h00, 8'h00, 1);
    rsp_is(STS_PROTECT, 8'h00, 1'b0, 40);
    pbp = 8'h00;
  endtask
  task automatic t_areas();
    lck = 8'h04;
    cfg = 8'h10;
    prot = 8'h20;
    enter();
    pkt(8'h81, CMD_ENC_WRITE, 8'h02, 8'h00, 3);
    rsp_is(STS_PROTECT, 8'h00, 1'b1, 40);
    ticks(2);
    chk("cmd_ready", 1, cmd_rdy);
    enter();
    pkt(8'h81, CMD_ENC_WRITE, 8'h04, 8'h00, 3);
    rsp_is(STS_OK, CMD_ENC_WRITE, 1'b0, 40);
    pkt(8'h81, CMD_ENC_WRITE, 8'h05, 8'h00, 3);
    rsp_is(STS_PROTECT, 8'h00, 1'b1, 40);
    enter();
    pkt(8'h81, CMD_ENC_WRITE, 8'h08, 8'h00, 3);
    rsp_is(STS_PARAM, 8'h00, 1'b1, 40);
    pbp = 8'h08;
    pkt(8'h01, CMD_USER_KEY, 8'h03, 8'h00, 2);
    rsp_is(STS_PROTECT, 8'h00, 1'b0, 40);
    pkt(8'h01, CMD_CERT_UPDATE, 8'h03, 8'h00, 2);
    rsp_is(STS_PROTECT, 8'h00, 1'b0, 40);
    pkt(8'h01, CMD_USER_KEY, 8'h02, 8'h00, 2);
    rsp_is(STS_OK, CMD_USER_KEY, 1'b0, 40);
    pbp = 8'h00;
    {lck, prot, cfg} = 24'h0;
    pkt(8'h01, 8'h00, 8'h00, 8'h00, 0);
    rsp_is(STS_PACKET, 8'h00, 1'b0, 40);
    pkt(8'h01, 8'h55, 8'h00, 8'h00, 1);
    rsp_is(STS_CMD_ACCEPT, 8'h00, 1'b0, 40);
  endtask
  task automatic t_lc(input logic ok, input logic answer);
    int k;
    k = 0;
    pkt(8'h01, CMD_LC_TRANSIT, 8'ha5, 8'h00, 2);
    while (lc_req !== 1'b1 && k < 40) begin
      @(negedge mclk);
      k++;
    end
    chk("lc_pattern", 8'ha5, lc_pat);
    if (answer) begin
      ticks(4);
      lc_ok = ok;
      lc_done = 1'b1;
      // Done drops on the falling edge that shows the answer, so one rising edge sees it.
      rsp_is(ok ? STS_OK : STS_HARDWARE, CMD_LC_TRANSIT, 1'b0, 3);
      lc_done = 1'b0;
    end else begin
      pkt(8'h01, 8'h55, 8'h00, 8'h00, 1);
      ticks(10);
      chk("rx_ready", 0, rx_ready);
      rsp_is(STS_HARDWARE, CMD_LC_TRANSIT, 1'b0, T_LC + 4);
      rsp_is(STS_CMD_ACCEPT, 8'h00, 1'b0, 30);
    end
  endtask
  initial begin
    rst = 1'b1;
    {boot, secp, osc, s1, s2, lc_done, lc_ok} = 7'h40;
    {pbp, lck, prot, cfg} = 32'h0;
    secp = 1'b1;
    ticks(16);
    rst = 1'b0;
    t_init();
    t_enc();
    t_areas();
    host.send(8'h01);
    host.send(8'h00);
    host.send(8'h01);
    host.send(8'h3a);
    host.send(8'h00);
    host.send(8'h03);
    rsp_is(STS_CHECKSUM, 8'h00, 1'b0, 40);
    t_lc(1'b1, 1'b1);
    t_lc(1'b0, 1'b1);
    t_lc(1'b0, 1'b0);
    tally_and_finish();
  end
endmodule // bewg_guard_test
